// file: logic/energy_pulse_config_word.v
// configuration word loader and pulse generation for a single-phase energy meter
// assumes energy increments and current magnitude come from logic on clk,
// and software loads the 70-bit word over an avalon-mm slave with waitrequest
//
// Contract
// RL1 - emit one internal pulse whenever the accumulator exceeds the pulse threshold
// RL2 - calibration rate equals stepper rate times the calibration multiplier
// RL3 - indicator rate depends only on the led rate select field
// RL4 - bench computes ideal threshold as 435924 scaled by 230V/Vmains and 20A/Imax
// RL5 - fixed-time method: threshold times counted over expected pulses
// RL6 - reference method: threshold times expected ratio over counted reference pulses
// RL7 - once bank one is selected and kept, bank zero is never used again
// RL8 - bench programs bank zero first, keeps bank one for a reprogramming
// RL9 - bench fills the unselected bank with zeros
// RL10 - bench always sets word bit zero to one when programming
// RL11 - the two top word bits are ignored
// RL12 - bank one fields sit at bits 67 down to 35
// RL13 - bank zero fields sit at bits 34 down to 2, bit 1 selects bank
// RL14 - gain code 00 gives 4; creep code 01 gives 7.43mA
// RL15 - led code 101 gives 3200 imp/kWh; multiplier code 10 gives x32
// RL16 - bench writes one complete 70-bit word
// RL17 - bit zero low uses defaults, high uses the selected bank
// RL18 - stepper 100..800, multiplier 8..64, led 100..6400 imp/kWh
// RL19 - defaults: gain 11, creep 01, motor 10, multiplier 01, led 101, 0x6a6d4
// RL20 - no output pulses while current is below the creep threshold
// RL21 - subtract threshold on each pulse, divide outputs by fixed ratios
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "epc_defines.vh"

module energy_pulse_config_word #(
  parameter INC_W = 16
) (
  input  wire             clk,
  input  wire             rst_n,
  // avalon-mm slave
  input  wire [7:0]       address,
  input  wire             read,
  input  wire             write,
  input  wire [31:0]      writedata,
  input  wire [3:0]       byteenable,
  output reg  [31:0]      readdata,
  output reg              waitrequest,
  // energy and current from the measurement path
  input  wire             energy_valid,
  input  wire [INC_W-1:0] energy_inc,
  input  wire [15:0]      current_ua,
  // pulse outputs
  output reg              internal_pulse,
  output reg  [1:0]       stepper_drive_pair,
  output reg              cal_pulse,
  output reg              led_pulse,
  output reg  [4:0]       gain_factor,
  output reg              creep_active
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // current channel gain per code
  function [4:0] gain_of;
    input [1:0] code;
    begin
      case (code)
        2'h0:    gain_of = 5'h04;                                         // RL14
        2'h1:    gain_of = 5'h10;
        2'h2:    gain_of = 5'h10;
        default: gain_of = 5'h14;
      endcase
    end
  endfunction

  // no-load cutoff in microamps per code
  function [15:0] creep_of;
    input [1:0] code;
    begin
      case (code)
        2'h0:    creep_of = `EPC_CREEP_UA_0;                              // RL20
        2'h1:    creep_of = `EPC_CREEP_UA_1;                              // RL14
        2'h2:    creep_of = `EPC_CREEP_UA_2;
        default: creep_of = `EPC_CREEP_UA_3;
      endcase
    end
  endfunction

  // merges a bus write into a stored word under byte enables
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration word and field selection

  reg  [69:0] word;
  reg         bank1_lock;
  wire        use_prog;
  wire        bank_used;
  wire [1:0]  gain_code;
  wire [1:0]  creep_code;
  wire [1:0]  mon_code;
  wire [1:0]  cal_code;
  wire [2:0]  led_code;
  wire [21:0] threshold;

  epc_field_select u_select (
    .word       (word),
    .bank1_lock (bank1_lock),
    .use_prog   (use_prog),
    .bank_used  (bank_used),
    .gain_code  (gain_code),
    .creep_code (creep_code),
    .mon_code   (mon_code),
    .cal_code   (cal_code),
    .led_code   (led_code),
    .threshold  (threshold)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  wire        req = read | write;
  wire        take = req & ~waitrequest;
  reg  [31:0] pulse_count;
  reg  [23:0] accum;
  reg  [31:0] next_readdata;

  // one wait cycle per access: waitrequest drops the cycle after a request appears
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else if (req && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // read mux; unmapped addresses read zero, top word bits read back as stored
  always @* begin
    next_readdata = 32'h0000_0000;
    if (address == `EPC_REG_WORD_LO) begin
      next_readdata = word[31:0];
    end else if (address == `EPC_REG_WORD_MID) begin
      next_readdata = word[63:32];
    end else if (address == `EPC_REG_WORD_HI) begin
      next_readdata = {26'h0000000, word[69:64]};
    end else if (address == `EPC_REG_STATUS) begin
      next_readdata = {16'h0000, creep_active, bank1_lock, bank_used, use_prog,
                       led_code, cal_code, mon_code, creep_code, 1'b0, gain_code};
    end else if (address == `EPC_REG_THRESHOLD) begin
      next_readdata = {10'h000, threshold};
    end else if (address == `EPC_REG_PULSE_COUNT) begin
      next_readdata = pulse_count;
    end else if (address == `EPC_REG_ACCUM) begin
      next_readdata = {8'h00, accum};
    end
  end

  // read data sampled while waiting, so it stands at the completing edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= next_readdata;
    end
  end

  // word writes land at the completing edge; bits 69:68 are stored but unused
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word <= 70'h0;
    end else if (take && write) begin
      if (address == `EPC_REG_WORD_LO) begin
        word[31:0] <= merge(word[31:0], writedata, byteenable);
      end else if (address == `EPC_REG_WORD_MID) begin
        word[63:32] <= merge(word[63:32], writedata, byteenable);
      end else if (address == `EPC_REG_WORD_HI) begin
        if (byteenable[0]) begin
          word[69:64] <= writedata[5:0];                                  // RL11
        end
      end
    end
  end

  // bank one choice is one-way: once a programmed word picks it, it sticks
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank1_lock <= 1'b0;
    end else if (word[`EPC_BIT_USE_PROG] && word[`EPC_BIT_BANK_CHOICE]) begin
      bank1_lock <= 1'b1;                                                 // RL7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator and internal pulse

  wire [23:0] inc_ext = energy_valid ? {{(24-INC_W){1'b0}}, energy_inc} : 24'h000000;
  wire [23:0] thr_ext = {2'h0, threshold};
  wire        over    = accum > thr_ext;
  wire        creep_block = current_ua < creep_of(creep_code);

  // below the creep cutoff nothing accumulates and nothing pulses
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accum          <= 24'h000000;
      internal_pulse <= 1'b0;
      creep_active   <= 1'b0;
      pulse_count    <= 32'h0000_0000;
    end else begin
      creep_active   <= creep_block;
      internal_pulse <= 1'b0;
      if (!creep_block) begin                                             // RL20
        if (over) begin
          accum          <= accum - thr_ext + inc_ext;                    // RL21
          internal_pulse <= 1'b1;                                         // RL1
          pulse_count    <= pulse_count + 32'h0000_0001;
        end else begin
          accum <= accum + inc_ext;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output rate dividers
  // the internal train counts as 51200 imp/kWh, the top calibration rate

  wire [2:0] cal_shift = `EPC_CAL_MAX_SHIFT - {1'b0, mon_code} - {1'b0, cal_code};
  wire [2:0] led_sel   = (led_code > `EPC_LED_MAX_CODE) ? `EPC_LED_MAX_CODE : led_code;
  wire [9:0] mon_ratio = `EPC_MON_BASE_RATIO >> mon_code;                 // RL18
  wire [9:0] cal_ratio = 10'h001 << cal_shift;                            // RL2
  wire [9:0] led_ratio = `EPC_LED_BASE_RATIO >> led_sel;                  // RL3
  wire       mon_tick;
  wire       cal_tick;
  wire       led_tick;

  // stepper rate: 100 << code imp/kWh
  epc_rate_divider #(.W(10)) u_mon_div (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (internal_pulse),
    .ratio (mon_ratio),
    .pulse (mon_tick)
  );

  // calibration rate: stepper rate times 8 << multiplier code
  epc_rate_divider #(.W(10)) u_cal_div (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (internal_pulse),
    .ratio (cal_ratio),
    .pulse (cal_tick)
  );

  // indicator rate: 100 << led code imp/kWh, code 7 held at 6400, multiplier plays no part
  epc_rate_divider #(.W(10)) u_led_div (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (internal_pulse),
    .ratio (led_ratio),
    .pulse (led_tick)
  );

  reg phase;

  // register outputs; stepper pulses alternate between the two coil phases
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stepper_drive_pair <= 2'h0;
      cal_pulse          <= 1'b0;
      led_pulse          <= 1'b0;
      phase              <= 1'b0;
      gain_factor        <= 5'h04;
    end else begin
      cal_pulse          <= cal_tick;                                     // RL15
      led_pulse          <= led_tick;
      gain_factor        <= gain_of(gain_code);
      stepper_drive_pair <= 2'h0;
      if (mon_tick) begin
        stepper_drive_pair <= phase ? 2'h2 : 2'h1;
        phase              <= ~phase;
      end
    end
  end

endmodule // energy_pulse_config_word

// file: logic/epc_defines.vh
// constants for the energy pulse configuration word loader
// assumes a 32-bit avalon-mm register bus, byte addresses, one clock
`ifndef EPC_DEFINES_VH
`define EPC_DEFINES_VH

// register byte offsets
`define EPC_REG_WORD_LO      8'h00
`define EPC_REG_WORD_MID     8'h04
`define EPC_REG_WORD_HI      8'h08
`define EPC_REG_STATUS       8'h0c
`define EPC_REG_THRESHOLD    8'h10
`define EPC_REG_PULSE_COUNT  8'h14
`define EPC_REG_ACCUM        8'h18

// word layout
`define EPC_WORD_BITS        70
`define EPC_BIT_USE_PROG     0
`define EPC_BIT_BANK_CHOICE  1
`define EPC_BANK1_SHIFT      33
`define EPC_GAIN_HI          34
`define EPC_GAIN_LO          33
`define EPC_CREEP_HI         32
`define EPC_CREEP_LO         31
`define EPC_MON_HI           30
`define EPC_MON_LO           29
`define EPC_CAL_HI           28
`define EPC_CAL_LO           27
`define EPC_LED_HI           26
`define EPC_LED_LO           24
`define EPC_THR_HI           23
`define EPC_THR_LO           2

// hard coded defaults
`define EPC_DEF_GAIN         2'h3
`define EPC_DEF_CREEP        2'h1
`define EPC_DEF_MON          2'h2
`define EPC_DEF_CAL          2'h1
`define EPC_DEF_LED          3'h5
`define EPC_DEF_THR          22'h06a6d4

// creep thresholds in microamps per code
`define EPC_CREEP_UA_0       16'h0910
`define EPC_CREEP_UA_1       16'h1d06
`define EPC_CREEP_UA_2       16'h3a34
`define EPC_CREEP_UA_3       16'h7404

// divider base ratios in internal pulses per output pulse, then the calibration shift and led code limits
`define EPC_MON_BASE_RATIO   10'h200
`define EPC_LED_BASE_RATIO   10'h200
`define EPC_CAL_MAX_SHIFT    3'h6
`define EPC_LED_MAX_CODE     3'h6

`endif

// file: logic/epc_field_select.v
// field selection from the configuration word: defaults, bank zero or bank one
// assumes the word and the bank lock come from flip-flops on the same clock
`timescale 1ns/100ps
`include "epc_defines.vh"

module epc_field_select (
  input  wire [69:0] word,
  input  wire        bank1_lock,
  output reg         use_prog,
  output reg         bank_used,
  output reg  [1:0]  gain_code,
  output reg  [1:0]  creep_code,
  output reg  [1:0]  mon_code,
  output reg  [1:0]  cal_code,
  output reg  [2:0]  led_code,
  output reg  [21:0] threshold
);

  reg [34:0] bank;

  // pick the bank, then the programmed or default values; bits 69:68 never read
  always @* begin
    use_prog  = word[`EPC_BIT_USE_PROG];                                  // RL17
    bank_used = word[`EPC_BIT_BANK_CHOICE] | bank1_lock;                  // RL7
    if (bank_used) begin
      bank = word[67:33] >> 0;                                            // RL12
    end else begin
      bank = word[34:0];                                                  // RL13
    end
    if (use_prog) begin
      gain_code  = bank[`EPC_GAIN_HI:`EPC_GAIN_LO];
      creep_code = bank[`EPC_CREEP_HI:`EPC_CREEP_LO];
      mon_code   = bank[`EPC_MON_HI:`EPC_MON_LO];
      cal_code   = bank[`EPC_CAL_HI:`EPC_CAL_LO];
      led_code   = bank[`EPC_LED_HI:`EPC_LED_LO];
      threshold  = bank[`EPC_THR_HI:`EPC_THR_LO];
    end else begin
      gain_code  = `EPC_DEF_GAIN;                                         // RL19
      creep_code = `EPC_DEF_CREEP;
      mon_code   = `EPC_DEF_MON;
      cal_code   = `EPC_DEF_CAL;
      led_code   = `EPC_DEF_LED;
      threshold  = `EPC_DEF_THR;
    end
  end

endmodule // epc_field_select

// file: logic/epc_rate_divider.v
// divides the internal pulse train by a run-time ratio
// assumes tick is a one-cycle pulse on the same clock
`timescale 1ns/100ps

module epc_rate_divider #(
  parameter W = 10
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         tick,
  input  wire [W-1:0] ratio,
  output reg          pulse
);

  reg [W-1:0] count;

  // count ticks, emit one pulse per ratio ticks; >= copes with a ratio that shrinks
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {W{1'b0}};
      pulse <= 1'b0;
    end else begin
      pulse <= 1'b0;
      if (tick) begin
        if (count + {{(W-1){1'b0}}, 1'b1} >= ratio) begin                 // RL21
          count <= {W{1'b0}};
          pulse <= 1'b1;
        end else begin
          count <= count + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // epc_rate_divider

// file: sim/epc_monitor.sv
// checker for the configuration word loader, bound to its top module
// assumes one clock domain and the active-low asynchronous reset rst_n
`timescale 1ns/100ps
module epc_monitor #(
  parameter INC_W = 16
) (
  input logic             clk,
  input logic             rst_n,
  input logic [7:0]       address,
  input logic             read,
  input logic             write,
  input logic [31:0]      writedata,
  input logic [3:0]       byteenable,
  input logic [31:0]      readdata,
  input logic             waitrequest,
  input logic             energy_valid,
  input logic [INC_W-1:0] energy_inc,
  input logic [15:0]      current_ua,
  input logic             internal_pulse,
  input logic [1:0]       stepper_drive_pair,
  input logic             cal_pulse,
  input logic             led_pulse,
  input logic [4:0]       gain_factor,
  input logic             creep_active
);
  logic [1:0] last_step;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////
  // last non-idle stepper phase, for the alternation check
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) last_step <= 2'h0;
    else if (stepper_drive_pair != 2'h0) last_step <= stepper_drive_pair;
  end
  //////////////////////////////////////////////////////////////////////
  // pulse path
  AST_CREEP_NO_INT: assert property (creep_active |-> !internal_pulse)
    else $error("internal pulse while creep active");
  AST_CREEP_QUIET: assert property (creep_active [*3] |-> !cal_pulse && !led_pulse && stepper_drive_pair == 2'h0)
    else $error("output pulse while creep active");
  AST_OUT_CAUSE: assert property ((cal_pulse || led_pulse || stepper_drive_pair != 2'h0) |-> $past(internal_pulse, 2))
    else $error("output pulse without internal pulse two cycles before");
  AST_STEP_EXCL: assert property (stepper_drive_pair != 2'h3)
    else $error("both stepper phases high");
  AST_STEP_ALT: assert property (stepper_drive_pair != 2'h0 |-> stepper_drive_pair != last_step)
    else $error("stepper phase repeated");
  AST_GAIN_CODE: assert property (gain_factor inside {5'h04, 5'h10, 5'h14})
    else $error("gain value outside table");
  // register bus
  AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  AST_WAIT_IDLE: assert property (!(read || write) |=> waitrequest)
    else $error("waitrequest low without request");
  C_CAL: cover property (cal_pulse);
  C_LED: cover property (led_pulse);
  C_STEP: cover property (stepper_drive_pair == 2'h2);
  C_CREEP: cover property (creep_active);
endmodule // epc_monitor

bind energy_pulse_config_word epc_monitor #(.INC_W(INC_W)) u_mon (
  .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .energy_valid(energy_valid),
  .energy_inc(energy_inc), .current_ua(current_ua), .internal_pulse(internal_pulse),
  .stepper_drive_pair(stepper_drive_pair), .cal_pulse(cal_pulse), .led_pulse(led_pulse),
  .gain_factor(gain_factor), .creep_active(creep_active));

// file: sim/cal_bench_model.sv
// calibration bench model: composes the whole 70-bit configuration word
// assumes the caller lets one clock edge pass before using word
`timescale 1ns/100ps
module cal_bench_model (
  input  logic        bank_sel,
  input  logic [1:0]  gain,
  input  logic [1:0]  creep,
  input  logic [1:0]  mon,
  input  logic [1:0]  cal,
  input  logic [2:0]  led,
  input  logic [21:0] thr,
  input  logic [1:0]  spare,
  output logic [69:0] word
);
  logic [32:0] fields;
  // one bank of fields, placed in the chosen bank, the other bank zero
  assign fields = {gain, creep, mon, cal, led, thr};
  assign word = {spare, bank_sel ? fields : 33'h0, bank_sel ? 33'h0 : fields, bank_sel, 1'b1};
endmodule // cal_bench_model

// file: sim/tb_top.sv
// self-checking bench for the configuration word loader
// assumes the avalon slave answers after one wait cycle as the design note says
`timescale 1ns/100ps
module tb_top;
  logic        clk, rst_n, read, write, energy_valid, internal_pulse, cal_pulse, led_pulse;
  logic        creep_active, waitrequest, m_bank;
  logic [7:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0]  byteenable;
  logic [15:0] energy_inc, current_ua;
  logic [1:0]  stepper_drive_pair, m_gain, m_creep, m_mon, m_cal, m_spare;
  logic [4:0]  gain_factor;
  logic [2:0]  m_led;
  logic [21:0] m_thr;
  logic [69:0] m_word;
  int          err_count, cmp_count, n_int, n_cal, n_led, n_stp, c, thr_v;
  energy_pulse_config_word #(.INC_W(16)) uut (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .energy_valid(energy_valid),
    .energy_inc(energy_inc), .current_ua(current_ua), .internal_pulse(internal_pulse),
    .stepper_drive_pair(stepper_drive_pair), .cal_pulse(cal_pulse), .led_pulse(led_pulse),
    .gain_factor(gain_factor), .creep_active(creep_active));
  cal_bench_model u_bench (.bank_sel(m_bank), .gain(m_gain), .creep(m_creep), .mon(m_mon), .cal(m_cal),
    .led(m_led), .thr(m_thr), .spare(m_spare), .word(m_word));
  //////////////////////////////////////////////////////////////////////
  // clock and output pulse counters
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (!rst_n) {n_int, n_cal, n_led, n_stp} <= '0;
    else begin
      n_int <= n_int + internal_pulse;
      n_cal <= n_cal + cal_pulse;
      n_led <= n_led + led_pulse;
      n_stp <= n_stp + (stepper_drive_pair != 2'h0);
    end
  end
  //////////////////////////////////////////////////////////////////////
  // report and end of run
  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // calibration arithmetic of the bench side, integer, rounded down except exp_pulses, which rounds to nearest
  function automatic int ideal_thr(input int vmains, input int imax);
    return 435924 * 230 * 20 / (vmains * imax);
  endfunction
  function automatic int exp_pulses(input int pr, input int tc, input int v, input int i);
    return (pr * tc * v * i + 1800000) / 3600000;
  endfunction
  function automatic int fixed_thr(input int ideal, input int nr, input int ni);
    return ideal * nr / ni;
  endfunction
  function automatic int ref_thr(input int ideal, input int ni, input int nr);
    return int'(longint'(ideal) * ni / nr);
  endfunction
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    q = readdata;
    if (i == 20) begin
      err_count++;
      summarize;
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rd);
    cmp(rd, exp);
  endtask
  task wr_word(input logic [69:0] w);
    bus(1'b1, 8'h00, w[31:0], rd);
    bus(1'b1, 8'h04, w[63:32], rd);
    bus(1'b1, 8'h08, {26'h0, w[69:64]}, rd);
  endtask
  task cfg(input logic b, input logic [1:0] g, cr, mo, ca, input logic [2:0] le, input logic [21:0] t);
    {m_bank, m_gain, m_creep, m_mon, m_cal, m_led, m_thr} = {b, g, cr, mo, ca, le, t};
    @(posedge clk);
  endtask
  task do_reset;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask
  task feed(input logic [15:0] inc, input int n);
    energy_valid <= 1'b1;
    energy_inc <= inc;
    repeat (n) @(posedge clk);
    energy_valid <= 1'b0;
    repeat (n + 100) @(posedge clk); // let the accumulator drain to the threshold or below
  endtask
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {clk, rst_n, read, write, energy_valid, m_bank} = '0;
    {address, writedata, energy_inc, m_gain, m_creep, m_mon, m_cal, m_led, m_thr, m_spare} = '0;
    {err_count, cmp_count} = '0;
    byteenable = 4'hf;
    current_ua = 16'h4e20;
    do_reset;
    rdchk(8'h10, 32'h0006a6d4);
    cmp({27'h0, gain_factor}, 32'h14);
    rdchk(8'h1c, 32'h0);
    // bank zero fields present but bit zero clear: defaults stay
    cfg(0, 2'h0, 2'h1, 2'h0, 2'h2, 3'h5, 22'h10);
    wr_word(m_word & ~70'h1);
    rdchk(8'h10, 32'h0006a6d4);
    wr_word(m_word);
    rdchk(8'h10, 32'h10);
    cmp({27'h0, gain_factor}, 32'h4);
    // threshold crossing is strict, residue kept
    feed(16'h10, 1);
    rdchk(8'h14, 32'h0);
    feed(16'h1, 1);
    rdchk(8'h14, 32'h1);
    rdchk(8'h18, 32'h1);
    // 6401 units over a threshold of 16: 400 more pulses, residue 1
    feed(16'h20, 200);
    rdchk(8'h14, 32'h191);
    cmp(n_int, 32'h191);
    rdchk(8'h18, 32'h1);
    cmp(n_led, 401 / 16);
    cmp(n_cal, 401 / 16);
    // below the creep threshold nothing moves
    current_ua <= 16'h0064;
    feed(16'h20, 50);
    rdchk(8'h14, 32'h191);
    cmp({31'h0, creep_active}, 32'h1);
    current_ua <= 16'h4e20;
    // rate codes: stepper 800, every multiplier, led codes 6 down to 3
    for (c = 0; c < 4; c++) begin
      do_reset;
      cfg(0, c[1:0], 2'h1, 2'h3, c[1:0], 3'(6 - c), 22'h10);
      wr_word(m_word);
      cmp({27'h0, gain_factor}, (c == 0) ? 32'h4 : (c == 3) ? 32'h14 : 32'h10);
      // 19200 units over a threshold of 16: 1199 pulses, residue 16
      feed(16'h20, 600);
      cmp(n_int, 1199);
      cmp(n_stp, 1199 / 64);
      cmp(n_cal, 1199 / (8 >> c));
      cmp(n_led, 1199 / (512 >> (6 - c)));
    end
    // bank zero first, then bank one, then the two top word bits written to ones
    do_reset;
    thr_v = fixed_thr(ideal_thr(230, 40), 170, exp_pulses(200 * 64, 20, 230, 10));
    cfg(0, 2'h2, 2'h1, 2'h1, 2'h1, 3'h1, thr_v[21:0]);
    wr_word(m_word);
    rdchk(8'h10, 32'h00037290);
    thr_v = ref_thr(ideal_thr(230, 20), 10000, 11000);
    cfg(1, 2'h1, 2'h1, 2'h0, 2'h0, 3'h0, thr_v[21:0]);
    wr_word(m_word);
    rdchk(8'h10, 32'h00060c06);
    cmp({27'h0, gain_factor}, 32'h10);
    bus(1'b1, 8'h08, {26'h0, 2'h3, m_word[67:64]}, rd);
    rdchk(8'h10, 32'h00060c06);
    cmp({27'h0, gain_factor}, 32'h10);
    // bank one stays in use; its fields are now the zeros of the unselected bank
    cfg(0, 2'h0, 2'h1, 2'h0, 2'h0, 3'h0, 22'h30);
    wr_word(m_word);
    rdchk(8'h10, 32'h0);
    rdchk(8'h0c, 32'h00007000);
    summarize;
  end
endmodule // tb_top
